/* File: common/mmd_params.svh */
// Named constants for the memory map size decoder.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef MMD_PARAMS_SVH
`define MMD_PARAMS_SVH

// Reset values of the two size selection registers
`define MMD_RST_MSS 8'hCF
`define MMD_RST_XSS 8'h0C

// Size register field layout and codes
`define MMD_ROM_FIELD 3:0
`define MMD_RAM_FIELD 7:5
`define MMD_RAM_1K 3'h6
`define MMD_XSS_1K 8'h0A

// Flash block geometry: 1 KB blocks, 4 KB ROM size steps
`define MMD_BLK_FIELD 15:10
`define MMD_ROM_STEP_FIELD 15:12

// Option byte and security identifier areas
`define MMD_OPT_LO 16'h0080
`define MMD_OPT_HI 16'h0084
`define MMD_SID_LO 16'h0085
`define MMD_SID_HI 16'h008E
`define MMD_SID_BASE 4'h5
`define MMD_DUP_PAGE 8'h10
`define MMD_DUP_OFS 16'h1000
`define MMD_PAGE_FIELD 15:8
`define MMD_OPT_IDX_FIELD 2:0
`define MMD_SID_IDX_FIELD 3:0

// Boot cluster 0 upper bound
`define MMD_BOOT0_HI 16'h0FFF

// Data memory areas
`define MMD_XRAM_LO 16'hF400
`define MMD_XRAM_HI 16'hF7FF
`define MMD_DSAD_LO 16'hFA26
`define MMD_DSAD_HI 16'hFA27
`define MMD_HSRAM_1K 16'hFB00
`define MMD_HSRAM_768 16'hFC00
`define MMD_HSRAM_HI 16'hFEFF
`define MMD_SFR_LO 16'hFF00

`endif

/* File: common/mmd_pkg.sv */
// Types shared by the memory map size decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package mmd_pkg;

  // Region that one decoded address falls in
  typedef enum logic [2:0] {
    RGN_NONE  = 3'b000,
    RGN_ROM   = 3'b001,
    RGN_HSRAM = 3'b010,
    RGN_XRAM  = 3'b011,
    RGN_SFR   = 3'b100,
    RGN_DSAD  = 3'b101
  } mmd_region_type;

endpackage : mmd_pkg

/* File: design/mmd_block_map.sv */
// Flash address to 1 KB block number, with range check against ROM size.
// Assumes a combinational use from the decoder on the same clock.
`timescale 1ns/10ps
`include "mmd_params.svh"

module mmd_block_map
  import mmd_pkg::*;
(
  // Address and selected ROM size in 4 KB steps
  input wire logic [15:0] addr,
  input wire logic [3:0] rom_steps,
  // Block number and its validity
  output logic [5:0] blk_num,
  output logic blk_ok
);

  // Four blocks per 4 KB step, so the last valid block is steps*4-1
  wire [5:0] blk_limit = {rom_steps, 2'h0};

  assign blk_num = addr[`MMD_BLK_FIELD];
  assign blk_ok = (blk_num < blk_limit);

endmodule : mmd_block_map

/* File: design/mmd_decoder.sv */
// Address decoder for a 64 KB flat map with size selection registers.
// Assumes the CPU core drives writes and accesses on clk_sys; security
// and boot swap levels come from logic on the same clock.
// Overview of operation
// (R1) One flat 16-bit address space of 64 KB holds every memory area.
// (R2) Size registers reset to CFH and 0CH whatever memory is fitted.
// (R3) Software writes 04H, C6H, C8H, CCH or CFH to match the ROM fitted.
// (R4) Software writes 0AH for 1 KB expansion RAM, else leaves 0CH.
// (R5) Without boot swap option bytes are 0080H-0084H, identifier 0085H-008EH.
// (R6) With boot swap the duplicates 1080H-1084H and 1085H-108EH also count.
// (R7) Writes to boot cluster 0 are blocked when security asks.
// (R8) Flash is split into equal 1 KB erase/write blocks.
// (R9) Block number is address divided by 1024.
// (R10) Valid blocks end at 0FH, 17H, 1FH, 2FH or 3BH by ROM size.
// (R11) FA26H and FA27H stay usable on converter variants.
// (R12) High-speed RAM is FC00H-FEFFH for 768 bytes, FB00H-FEFFH for 1 KB.
// (R13) Addresses past the selected sizes are outside internal ROM and RAM.
`timescale 1ns/10ps
`include "mmd_params.svh"

module mmd_decoder
  import mmd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Size register writes from the CPU core
  input wire logic mss_wr,
  input wire logic [7:0] mss_wdata,
  input wire logic xss_wr,
  input wire logic [7:0] xss_wdata,
  // CPU access request
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [15:0] acc_addr,
  // Security, boot swap and variant levels
  input wire logic boot_swap_en,
  input wire logic boot0_wprot,
  input wire logic dsad_fitted,
  // Size register readback
  output logic [7:0] mem_size_select,
  output logic [7:0] exp_ram_size_select,
  // Decode result, one cycle after the request
  output logic dec_valid,
  output mmd_region_type region,
  output logic opt_hit,
  output logic [2:0] opt_index,
  output logic secid_hit,
  output logic [3:0] secid_index,
  output logic [5:0] flash_block,
  output logic block_valid,
  output logic write_blocked
);

  logic [7:0] mss_q;
  logic [7:0] xss_q;
  logic dec_valid_q;
  mmd_region_type region_q;
  mmd_region_type region_d;
  logic opt_hit_q;
  logic [2:0] opt_index_q;
  logic secid_hit_q;
  logic [3:0] secid_index_q;
  logic [5:0] block_q;
  logic block_ok_q;
  logic wblk_q;
  logic [5:0] blk_num;
  logic blk_ok;

  // Size registers; software must load the product value after reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mss_q <= `MMD_RST_MSS; // R2
      xss_q <= `MMD_RST_XSS; // R2
    end else begin
      if (mss_wr) mss_q <= mss_wdata; // R3
      if (xss_wr) xss_q <= xss_wdata; // R4
    end
  end

  // Size fields: only the 1 KB code widens high-speed RAM downwards
  wire [3:0] rom_steps = mss_q[`MMD_ROM_FIELD];
  wire ram_1k = (mss_q[`MMD_RAM_FIELD] == `MMD_RAM_1K);
  wire xram_on = (xss_q == `MMD_XSS_1K);
  wire [15:0] hsram_lo = ram_1k ? `MMD_HSRAM_1K : `MMD_HSRAM_768;

  // Area hits over the whole 16-bit space
  wire hit_rom = (acc_addr[`MMD_ROM_STEP_FIELD] < rom_steps); // R13
  wire hit_hsram = (acc_addr >= hsram_lo) && (acc_addr <= `MMD_HSRAM_HI); // R12
  wire hit_xram = xram_on && (acc_addr >= `MMD_XRAM_LO) && (acc_addr <= `MMD_XRAM_HI); // R13
  wire hit_dsad = dsad_fitted && (acc_addr >= `MMD_DSAD_LO) && (acc_addr <= `MMD_DSAD_HI); // R11
  wire hit_sfr = (acc_addr >= `MMD_SFR_LO);

  // Region priority; ROM never reaches the data areas at the top
  always_comb begin
    region_d = RGN_NONE; // R1
    if (hit_sfr) region_d = RGN_SFR;
    else if (hit_hsram) region_d = RGN_HSRAM; // R12
    else if (hit_dsad) region_d = RGN_DSAD; // R11
    else if (hit_xram) region_d = RGN_XRAM;
    else if (hit_rom) region_d = RGN_ROM; // R13
  end

  // Duplicate page folds onto the primary page only under boot swap
  wire dup_page = boot_swap_en && (acc_addr[`MMD_PAGE_FIELD] == `MMD_DUP_PAGE); // R6
  wire [15:0] fold_addr = dup_page ? (acc_addr ^ `MMD_DUP_OFS) : acc_addr;
  wire hit_opt = (fold_addr >= `MMD_OPT_LO) && (fold_addr <= `MMD_OPT_HI); // R5
  wire hit_sid = (fold_addr >= `MMD_SID_LO) && (fold_addr <= `MMD_SID_HI); // R5
  wire [3:0] sid_idx = fold_addr[`MMD_SID_IDX_FIELD] - `MMD_SID_BASE;

  // Boot cluster 0 write inhibit, judged on the raw address
  wire boot0_block = acc_write && boot0_wprot && (acc_addr <= `MMD_BOOT0_HI); // R7

  // Block number and range for the selected ROM size
  mmd_block_map u_block_map ( // R8
    .addr(acc_addr),
    .rom_steps(rom_steps),
    .blk_num(blk_num),
    .blk_ok(blk_ok)
  );

  // Result registers; all but dec_valid held between requests so the CPU may sample late
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dec_valid_q <= 1'b0;
      region_q <= RGN_NONE;
      opt_hit_q <= 1'b0;
      opt_index_q <= 3'h0;
      secid_hit_q <= 1'b0;
      secid_index_q <= 4'h0;
      block_q <= 6'h00;
      block_ok_q <= 1'b0;
      wblk_q <= 1'b0;
    end else begin
      dec_valid_q <= acc_valid;
      if (acc_valid) begin
        region_q <= region_d;
        opt_hit_q <= hit_opt; // R5
        opt_index_q <= hit_opt ? fold_addr[`MMD_OPT_IDX_FIELD] : 3'h0;
        secid_hit_q <= hit_sid; // R6
        secid_index_q <= hit_sid ? sid_idx : 4'h0;
        block_q <= blk_num; // R9
        block_ok_q <= blk_ok; // R10
        wblk_q <= boot0_block; // R7
      end
    end
  end

  // Outputs straight from flip-flops
  assign mem_size_select = mss_q;
  assign exp_ram_size_select = xss_q;
  assign dec_valid = dec_valid_q;
  assign region = region_q;
  assign opt_hit = opt_hit_q;
  assign opt_index = opt_index_q;
  assign secid_hit = secid_hit_q;
  assign secid_index = secid_index_q;
  assign flash_block = block_q;
  assign block_valid = block_ok_q;
  assign write_blocked = wblk_q;

  // Checks: all but AST_RESET_VALUES tie a decoded result to the request one cycle earlier
  AST_RESET_VALUES: assert property (@(posedge clk_sys) $rose(resetn) |-> // R2
    (mss_q == `MMD_RST_MSS) && (xss_q == `MMD_RST_XSS))
    else $error("size registers not at reset values");

  AST_ANSWER_NEXT: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
    acc_valid |=> dec_valid ##1 (dec_valid == $past(acc_valid)))
    else $error("decode answer not one cycle after request");

  AST_OPT_PRIMARY: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
    acc_valid && (acc_addr >= `MMD_OPT_LO) && (acc_addr <= `MMD_OPT_HI)
    |=> opt_hit && (opt_index == $past(acc_addr[`MMD_OPT_IDX_FIELD])))
    else $error("option byte area not decoded");

  AST_NO_DUP: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
    acc_valid && !boot_swap_en && (acc_addr[`MMD_PAGE_FIELD] == `MMD_DUP_PAGE) |=> !opt_hit && !secid_hit)
    else $error("duplicate area decoded without boot swap");

  AST_SID_DUP: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
    acc_valid && boot_swap_en && (acc_addr == (`MMD_SID_HI | `MMD_DUP_OFS))
    |=> secid_hit && (secid_index == 4'h9))
    else $error("duplicate identifier area not decoded");

  AST_BOOT0_WPROT: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
    acc_valid && acc_write && boot0_wprot && (acc_addr <= `MMD_BOOT0_HI) |=> write_blocked)
    else $error("boot cluster 0 write not blocked");

  AST_BLOCK_NUM: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
    acc_valid |=> (flash_block == $past(acc_addr[`MMD_BLK_FIELD])))
    else $error("block number is not address divided by 1024");

  AST_BLOCK_RANGE: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
    acc_valid && (mss_q == `MMD_RST_MSS) |=> (block_valid == (flash_block <= 6'h3B)))
    else $error("block range wrong for largest ROM");

  AST_DSAD_KEEP: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
    acc_valid && dsad_fitted && (acc_addr == `MMD_DSAD_HI) |=> (region == RGN_DSAD))
    else $error("converter address not decoded");

  AST_HSRAM_1K: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
    acc_valid && ram_1k && (acc_addr == `MMD_HSRAM_1K) |=> (region == RGN_HSRAM))
    else $error("1 KB high-speed RAM base not decoded");

  AST_ROM_LIMIT: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
    acc_valid && (acc_addr[`MMD_ROM_STEP_FIELD] >= rom_steps) |=> (region != RGN_ROM))
    else $error("address beyond ROM size decoded as ROM");

  // The register page at the top wins over every memory area
  AST_SFR_TOP: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
    acc_valid && (acc_addr >= `MMD_SFR_LO) |=> (region == RGN_SFR))
    else $error("register page not decoded");

  // Expansion RAM exists only while its size code selects it
  AST_XRAM_SIZE: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
    acc_valid && (acc_addr >= `MMD_XRAM_LO) && (acc_addr <= `MMD_XRAM_HI)
    |=> ((region == RGN_XRAM) == $past(xram_on)))
    else $error("expansion RAM decode does not follow its size code");

  AST_HSRAM_768: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
    acc_valid && !ram_1k && (acc_addr >= `MMD_HSRAM_1K) && (acc_addr < `MMD_HSRAM_768)
    |=> (region != RGN_HSRAM))
    else $error("768-byte high-speed RAM decoded too low");

  // Reads and unprotected writes must never be inhibited
  AST_BOOT0_FREE: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
    acc_valid && !(acc_write && boot0_wprot) |=> !write_blocked)
    else $error("access blocked without a protected write");

endmodule : mmd_decoder

/* File: test/mmd_cpu_model.sv */
// CPU core model: size register writes and decode requests.
// Assumes a free-running clk_sys; drives only on the falling edge.
`timescale 1ns/10ps
module mmd_cpu_model (
  // Clock
  input wire logic clk_sys,
  // Size register writes
  output logic mss_wr,
  output logic [7:0] mss_wdata,
  output logic xss_wr,
  output logic [7:0] xss_wdata,
  // Access request
  output logic acc_valid,
  output logic acc_write,
  output logic [15:0] acc_addr
);
  // Quiet bus at time zero
  initial begin
    mss_wr = 1'b0;
    mss_wdata = 8'h00;
    xss_wr = 1'b0;
    xss_wdata = 8'h00;
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr = 16'h0000;
  end

  // Startup software sets both size registers in one strobe cycle
  task wr_sizes(input logic [7:0] m, input logic [7:0] x);
    @(negedge clk_sys);
    mss_wr = 1'b1;
    mss_wdata = m;
    xss_wr = 1'b1;
    xss_wdata = x;
    @(negedge clk_sys);
    mss_wr = 1'b0;
    xss_wr = 1'b0;
    // Released data is scrambled so a late sample cannot pass
    mss_wdata = ~m;
    xss_wdata = ~x;
  endtask : wr_sizes

  // One request; returns one half cycle after the taking edge
  task access(input logic [15:0] a, input logic w);
    @(negedge clk_sys);
    acc_valid = 1'b1;
    acc_write = w;
    acc_addr = a;
    @(negedge clk_sys);
    acc_valid = 1'b0;
    acc_write = ~w;
    acc_addr = ~a;
  endtask : access
endmodule : mmd_cpu_model

/* File: test/mmd_decoder_tb_top.sv */
// Self-checking bench for the address decoder.
// Assumes the CPU model drives requests; levels are set here on falling edges.
`timescale 1ns/10ps
module mmd_decoder_tb_top
  import mmd_pkg::*;
();
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic boot_swap_en = 1'b0;
  logic boot0_wprot = 1'b0;
  logic dsad_fitted = 1'b0;
  logic mss_wr, xss_wr, acc_valid, acc_write;
  logic [7:0] mss_wdata, xss_wdata, mem_size_select, exp_ram_size_select;
  logic [15:0] acc_addr;
  logic dec_valid, opt_hit, secid_hit, block_valid, write_blocked;
  logic [2:0] opt_index;
  logic [3:0] secid_index;
  logic [5:0] flash_block;
  mmd_region_type region;
  int failures = 0;
  int checks_done = 0;
  // Variant table: size codes and last valid block
  logic [7:0] mss_t [5] = '{8'h04, 8'hC6, 8'hC8, 8'hCC, 8'hCF};
  logic [7:0] xss_t [5] = '{8'h0C, 8'h0C, 8'h0C, 8'h0A, 8'h0A};
  logic [5:0] last_t [5] = '{6'h0F, 6'h17, 6'h1F, 6'h2F, 6'h3B};

  always #5 clk_sys = ~clk_sys;

  mmd_cpu_model cpu (.clk_sys(clk_sys), .mss_wr(mss_wr), .mss_wdata(mss_wdata), .xss_wr(xss_wr),
    .xss_wdata(xss_wdata), .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr));

  mmd_decoder dut (.clk_sys(clk_sys), .resetn(resetn), .mss_wr(mss_wr), .mss_wdata(mss_wdata),
    .xss_wr(xss_wr), .xss_wdata(xss_wdata), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .boot_swap_en(boot_swap_en), .boot0_wprot(boot0_wprot),
    .dsad_fitted(dsad_fitted), .mem_size_select(mem_size_select),
    .exp_ram_size_select(exp_ram_size_select), .dec_valid(dec_valid), .region(region),
    .opt_hit(opt_hit), .opt_index(opt_index), .secid_hit(secid_hit), .secid_index(secid_index),
    .flash_block(flash_block), .block_valid(block_valid), .write_blocked(write_blocked));

  // Shared compare, four-state so an unknown never matches
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request, check region, then check the valid pulse lasts one cycle only
  task probe(input logic [15:0] a, input logic w, input mmd_region_type r);
    cpu.access(a, w);
    chk(16'(dec_valid), 16'h0001);
    chk(16'(region), 16'(r));
    @(negedge clk_sys);
    chk(16'(dec_valid), 16'h0000);
  endtask : probe

  task chk_id(input logic [15:0] a, input logic oh, input logic [2:0] oi, input logic sh, input logic [3:0] si);
    cpu.access(a, 1'b0);
    chk(16'({opt_hit, opt_index, secid_hit, secid_index}), 16'({oh, oi, sh, si}));
  endtask : chk_id

  // Reset values hold whatever was written before
  task test_reset;
    @(negedge clk_sys);
    resetn = 1'b0;
    @(negedge clk_sys);
    chk(16'({mem_size_select, exp_ram_size_select}), 16'hCF0C);
    chk(16'({dec_valid, region}), 16'h0000);
    resetn = 1'b1;
  endtask : test_reset

  // Every variant: ROM end, first address past it, both RAM areas
  task test_sizes;
    for (int i = 0; i < 5; i++) begin
      cpu.wr_sizes(mss_t[i], xss_t[i]);
      chk(16'({mem_size_select, exp_ram_size_select}), {mss_t[i], xss_t[i]});
      probe({last_t[i], 10'h3FF}, 1'b0, RGN_ROM);
      chk(16'({block_valid, flash_block}), 16'({1'b1, last_t[i]}));
      probe({last_t[i] + 6'h01, 10'h000}, 1'b0, RGN_NONE);
      chk(16'(block_valid), 16'h0000);
      probe(16'hFB00, 1'b0, (mss_t[i][7:5] == 3'h6) ? RGN_HSRAM : RGN_NONE);
      probe(16'hFC00, 1'b0, RGN_HSRAM);
      probe(16'hF400, 1'b0, (xss_t[i] == 8'h0A) ? RGN_XRAM : RGN_NONE);
    end
  endtask : test_sizes

  // Option and identifier areas, duplicates only under boot swap
  task test_ids;
    for (int s = 0; s < 2; s++) begin
      boot_swap_en = s[0];
      chk_id(16'h0080, 1'b1, 3'h0, 1'b0, 4'h0);
      chk_id(16'h0084, 1'b1, 3'h4, 1'b0, 4'h0);
      chk_id(16'h0085, 1'b0, 3'h0, 1'b1, 4'h0);
      chk_id(16'h008E, 1'b0, 3'h0, 1'b1, 4'h9);
      chk_id(16'h008F, 1'b0, 3'h0, 1'b0, 4'h0);
      chk_id(16'h1084, s[0], {s[0], 2'b00}, 1'b0, 4'h0);
      chk_id(16'h108E, 1'b0, 3'h0, s[0], {s[0], 2'b00, s[0]});
    end
  endtask : test_ids

  // Write inhibit on cluster 0 edges, reads never blocked
  task test_wprot;
    boot0_wprot = 1'b1;
    cpu.access(16'h0FFF, 1'b1);
    chk(16'(write_blocked), 16'h0001);
    cpu.access(16'h1000, 1'b1);
    chk(16'(write_blocked), 16'h0000);
    cpu.access(16'h0000, 1'b0);
    chk(16'(write_blocked), 16'h0000);
    boot0_wprot = 1'b0;
    cpu.access(16'h0000, 1'b1);
    chk(16'(write_blocked), 16'h0000);
  endtask : test_wprot

  // Converter pair and the top of the map
  task test_top;
    dsad_fitted = 1'b1;
    probe(16'hFA26, 1'b0, RGN_DSAD);
    probe(16'hFA27, 1'b1, RGN_DSAD);
    probe(16'hFA28, 1'b0, RGN_NONE);
    dsad_fitted = 1'b0;
    probe(16'hFA26, 1'b0, RGN_NONE);
    probe(16'hFFFF, 1'b0, RGN_SFR);
    probe(16'hFEFF, 1'b0, RGN_HSRAM);
  endtask : test_top

  task test_done;
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    test_reset();
    test_sizes();
    test_ids();
    test_wprot();
    test_reset();
    test_top();
    test_done();
  end
endmodule : mmd_decoder_tb_top
